// file: src/bhr_recovery.sv
// Bus hang recovery engine for the clock and data lines of the two-wire bus.
`timescale 1ns/1ps
`default_nettype none
module bhr_recovery
    import bhr_pkg::*;
#(
    parameter int HALF_CYC = bhr_pkg::HALF_PERIOD_CYC,
    parameter int PULSES = bhr_pkg::MAX_PULSES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic recover_req,
    input wire logic clear_status,
    input wire logic scl_in,
    input wire logic sda_in,
    output bhr_pkg::bhr_pin_type scl_drive,
    output bhr_pkg::bhr_pin_type sda_drive,
    output bhr_pkg::bhr_status_type status,
    output logic transfer_allowed
);
    import bhr_pkg::*;

    localparam bit HALF_BAD = (HALF_CYC < 1) || (HALF_CYC >= (1 << CNT_W));
    localparam bit PULSE_BAD = (PULSES < 1) || (PULSES >= (1 << PULSE_W));

    // The timer and pulse counters cannot hold values outside these bounds.
    if (HALF_BAD || PULSE_BAD) begin : g_bad_params
        $error("bhr_recovery: parameter out of range");
    end

    localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_CYC - 1);
    localparam logic [PULSE_W-1:0] PULSE_LAST = PULSE_W'(PULSES);

    bhr_state_type state;
    bhr_state_type next_state;
    logic [CNT_W-1:0] timer;
    logic [PULSE_W-1:0] pulses;
    logic scl_s;
    logic sda_s;
    logic done_flag;
    logic fail_flag;

    bhr_sync #(.RESET_VALUE(1'b1)) u_sync_scl (
        .clk(clk),
        .reset(reset),
        .din(scl_in),
        .dout(scl_s)
    );
    bhr_sync #(.RESET_VALUE(1'b1)) u_sync_sda (
        .clk(clk),
        .reset(reset),
        .din(sda_in),
        .dout(sda_s)
    );

    wire timer_done = (timer == HALF_LAST);
    wire bus_hung = ~sda_s;
    wire last_pulse = (pulses == PULSE_LAST);
    // High phase waits for the clock to really be high, so a stretching slave is honoured.
    wire high_ok = timer_done & scl_s;

    always_comb begin
        next_state = state;
        case (state)
            BHR_IDLE: begin
                if (recover_req & bus_hung)
                    next_state = BHR_LOW;
            end
            BHR_LOW: begin
                if (timer_done)
                    next_state = BHR_HIGH;
            end
            BHR_HIGH: begin
                if (high_ok & sda_s)
                    next_state = BHR_START;
                else if (high_ok & last_pulse)
                    next_state = BHR_FAIL;
                else if (high_ok)
                    next_state = BHR_LOW;
            end
            BHR_START: begin
                if (timer_done)
                    next_state = BHR_DONE;
            end
            BHR_DONE: begin
                if (timer_done)
                    next_state = BHR_IDLE;
            end
            BHR_FAIL: begin
                next_state = BHR_IDLE;
            end
            default: begin
                next_state = BHR_IDLE;
            end
        endcase
    end

    wire state_change = (next_state != state);
    wire in_idle = (state == BHR_IDLE);
    wire in_low = (state == BHR_LOW);
    wire in_done = (state == BHR_DONE);
    wire in_fail = (state == BHR_FAIL);
    wire next_idle = (next_state == BHR_IDLE);
    wire pulse_begin = in_low & timer_done;
    // Clock driven low in the low phase, and data pulled low for the start condition.
    wire next_scl_low = (next_state == BHR_LOW);
    wire next_sda_low = (next_state == BHR_START);
    wire set_done = in_done & timer_done;
    wire set_fail = in_fail;
    // The timer restarts on each state change, so every phase gets its full length.
    wire [CNT_W-1:0] next_timer = (state_change | timer_done) ? '0 : timer + 1'b1;
    // The count is cleared in idle, so each recovery gets all of its pulses.
    wire [PULSE_W-1:0] pulses_inc = pulse_begin ? pulses + 1'b1 : pulses;
    wire [PULSE_W-1:0] next_pulses = in_idle ? '0 : pulses_inc;
    // Set wins over clear for both sticky flags.
    wire next_done_flag = set_done | (done_flag & ~clear_status);
    wire next_fail_flag = set_fail | (fail_flag & ~clear_status);
    wire next_allowed = next_idle & sda_s;
    bhr_pin_type next_scl_drive;
    bhr_pin_type next_sda_drive;
    bhr_status_type next_status;

    assign next_scl_drive = '{out: 1'b0, oe: next_scl_low};
    assign next_sda_drive = '{out: 1'b0, oe: next_sda_low};
    assign next_status = '{
        busy: ~next_idle,
        done: done_flag,
        failed: fail_flag,
        hung: bus_hung
    };

    // Recovery state.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= BHR_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Phase timer.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            timer <= '0;
        end else begin
            timer <= next_timer;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pulses <= '0;
        end else begin
            pulses <= next_pulses;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            scl_drive <= '0;
        end else begin
            scl_drive <= next_scl_drive;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sda_drive <= '0;
        end else begin
            sda_drive <= next_sda_drive;
        end
    end

    // Done flag.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            done_flag <= 1'b0;
        end else begin
            done_flag <= next_done_flag;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fail_flag <= 1'b0;
        end else begin
            fail_flag <= next_fail_flag;
        end
    end

    // Status word.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            status <= '0;
        end else begin
            status <= next_status;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            transfer_allowed <= 1'b0;
        end else begin
            transfer_allowed <= next_allowed;
        end
    end
endmodule : bhr_recovery
`default_nettype wire

// file: src/bhr_pkg.sv
// Package of constants and types for the bus hang recovery block.
`default_nettype none
package bhr_pkg;
    // Clock rate and recovery timing.
    localparam int CLK_HZ = 20_000_000;
    localparam int HALF_PERIOD_NS = 5000;
    localparam int HALF_PERIOD_CYC =
        (HALF_PERIOD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int MAX_PULSES = 9;
    localparam int CNT_W = 16;
    localparam int PULSE_W = 4;

    typedef enum logic [5:0] {
        BHR_IDLE = 6'h01,
        BHR_LOW = 6'h02,
        BHR_HIGH = 6'h04,
        BHR_START = 6'h08,
        BHR_DONE = 6'h10,
        BHR_FAIL = 6'h20
    } bhr_state_type;

    // Open-drain pin drive: output value and enable.
    typedef struct packed {
        logic out;
        logic oe;
    } bhr_pin_type;

    typedef struct packed {
        logic busy;
        logic done;
        logic failed;
        logic hung;
    } bhr_status_type;
endpackage : bhr_pkg
`default_nettype wire

// file: src/bhr_sync.sv
// Two flip-flop synchroniser for a pin level.
`timescale 1ns/1ps
`default_nettype none
module bhr_sync #(
    parameter logic RESET_VALUE = 1'b1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic din,
    output logic dout
);
    logic stage1;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stage1 <= RESET_VALUE;
            dout <= RESET_VALUE;
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule : bhr_sync
`default_nettype wire

// file: tb/bhr_recovery_properties.sv
// Port checker for the bus hang recovery engine.
`timescale 1ns/1ps
`default_nettype none
module bhr_recovery_properties
    import bhr_pkg::*;
#(
    parameter int HALF_CYC = bhr_pkg::HALF_PERIOD_CYC,
    parameter int PULSES = bhr_pkg::MAX_PULSES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic recover_req,
    input wire logic clear_status,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire bhr_pkg::bhr_pin_type scl_drive,
    input wire bhr_pkg::bhr_pin_type sda_drive,
    input wire bhr_pkg::bhr_status_type status,
    input wire logic transfer_allowed
);
    logic [3:0] pulses;
    logic [15:0] low_cnt;
    // Counts clock pulses since the current recovery began.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pulses <= 4'h0;
        end else begin
            pulses <= ($rose(status.busy) ? 4'h0 : pulses) + 4'($rose(scl_drive.oe));
        end
    end
    // Counts cycles that the clock has been held low in the current phase.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            low_cnt <= 16'h0000;
        end else begin
            low_cnt <= scl_drive.oe ? low_cnt + 16'h0001 : 16'h0000;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_start;
        $rose(sda_drive.oe);
    endsequence
    property p_no_xfer; transfer_allowed |-> !status.hung && !status.busy; endproperty
    a_no_xfer: assert property (p_no_xfer) else $error("transfer while hung");
    property p_max; pulses <= 4'(PULSES); endproperty
    a_max: assert property (p_max) else $error("too many pulses");
    property p_sample; s_start |-> scl_in && $past(sda_in); endproperty
    a_sample: assert property (p_sample) else $error("start without high data");
    property p_stop; sda_drive.oe |-> !scl_drive.oe; endproperty
    a_stop: assert property (p_stop) else $error("pulsing during start");
    property p_fail; $rose(status.failed) |-> pulses == 4'(PULSES); endproperty
    a_fail: assert property (p_fail) else $error("failed before last pulse");
    property p_low; $fell(scl_drive.oe) |-> low_cnt == 16'(HALF_CYC); endproperty
    a_low: assert property (p_low) else $error("clock low phase has wrong length");
endmodule : bhr_recovery_properties
bind bhr_recovery bhr_recovery_properties #(.HALF_CYC(HALF_CYC), .PULSES(PULSES)) u_props (
    .clk(clk),
    .reset(reset),
    .recover_req(recover_req),
    .clear_status(clear_status),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_drive(scl_drive),
    .sda_drive(sda_drive),
    .status(status),
    .transfer_allowed(transfer_allowed)
);
`default_nettype wire

// file: tb/bhr_slave.sv
// Slave left holding the data line low by an interrupted read.
`timescale 1ns/1ps
`default_nettype none
module bhr_slave (
    input wire logic scl,
    input wire logic [3:0] hold,
    input wire logic arm,
    output logic sda_oe
);
    logic [3:0] left;
    initial sda_oe = 1'h0;
    always @(posedge arm or negedge scl) begin
        if (arm) begin
            sda_oe <= 1'h1;
            left <= hold;
        end else if (left != 4'h0) begin
            left <= left - 4'h1;
            sda_oe <= (left > 4'h1);
        end
    end
endmodule : bhr_slave
`default_nettype wire

// file: tb/tb_bhr_recovery.sv
// Self-checking bench for the bus hang recovery engine.
`timescale 1ns/1ps
`default_nettype none
module tb_bhr_recovery;
    import bhr_pkg::*;
    logic clk = 1'h0;
    logic reset = 1'h1;
    logic recover_req = 1'h0;
    logic clear_status = 1'h0;
    logic arm = 1'h0;
    logic [3:0] hold = 4'h0;
    logic slave_oe;
    bhr_pin_type scl_drive;
    bhr_pin_type sda_drive;
    bhr_status_type status;
    logic transfer_allowed;
    int miscompares = 0;
    int cmp_count = 0;
    int falls = 0;
    int starts = 0;
    // Pull-ups keep both lines high unless someone pulls them low.
    wire logic scl = !scl_drive.oe;
    wire logic sda = !(sda_drive.oe || slave_oe);
    always #25 clk = !clk;
    // Clock pulses and start conditions seen on the bus.
    always @(negedge scl) falls++;
    always @(posedge sda_drive.oe) begin
        if (scl)
            starts++;
    end
    bhr_recovery #(.HALF_CYC(4), .PULSES(9)) uut (.clk(clk), .reset(reset),
        .recover_req(recover_req), .clear_status(clear_status), .scl_in(scl), .sda_in(sda),
        .scl_drive(scl_drive), .sda_drive(sda_drive), .status(status),
        .transfer_allowed(transfer_allowed));
    bhr_slave slave (.scl(scl), .hold(hold), .arm(arm), .sda_oe(slave_oe));
    task automatic chk(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t mismatch", $time);
        end
    endtask : chk
    task automatic chk_n(input int got, input int exp);
        cmp_count++;
        if (got != exp) begin
            miscompares++;
            $display("ERROR %0t count mismatch", $time);
        end
    endtask : chk_n
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask : step
    // The slave is armed first so the request sees a hung bus.
    task automatic run(input logic [3:0] h);
        hold = h;
        falls = 0;
        starts = 0;
        arm = 1'h1;
        step(1);
        arm = 1'h0;
        recover_req = 1'h1;
        step(4);
        recover_req = 1'h0;
        for (int i = 0; status.busy !== 1'h0; i++) begin
            if (i == 400) begin
                miscompares++;
                report_and_stop();
            end
            step(1);
        end
        step(3);
    endtask : run
    task automatic t_idle();
        recover_req = 1'h1;
        step(4);
        chk(status.busy, 1'h0);
        chk(transfer_allowed, 1'h1);
        recover_req = 1'h0;
        $display("test idle done");
    endtask : t_idle
    task automatic t_clear();
        run(4'h3);
        chk(status.done, 1'h1);
        chk(status.failed, 1'h0);
        chk(transfer_allowed, 1'h1);
        chk_n(falls, 3);
        chk_n(starts, 1);
        chk(scl_drive.out, 1'h0);
        chk(sda_drive.out, 1'h0);
        $display("test clear done");
    endtask : t_clear
    task automatic t_fail();
        clear_status = 1'h1;
        step(1);
        clear_status = 1'h0;
        run(4'hF);
        chk(status.failed, 1'h1);
        chk(status.hung, 1'h1);
        chk(transfer_allowed, 1'h0);
        chk_n(falls, 9);
        chk_n(starts, 0);
        chk(status.done, 1'h0);
        clear_status = 1'h1;
        step(2);
        chk(status.failed, 1'h0);
        clear_status = 1'h0;
        $display("test fail done");
    endtask : t_fail
    initial begin
        step(20);
        reset = 1'h0;
        step(3);
        t_idle();
        t_clear();
        t_fail();
        report_and_stop();
    end
endmodule : tb_bhr_recovery
`default_nettype wire
